// ===== src/coef_store.sv
// Coefficient memory holding the unique half of the symmetric response
`timescale 1ns/100ps
`default_nettype none
module coef_store #(
   parameter int COEF_W = 16,
   parameter int DEPTH = 256,
   parameter int PORTS = 16
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [COEF_W-1:0] wr_data,
   input wire logic [PORTS-1:0][7:0] rd_addr,
   output logic [PORTS-1:0][COEF_W-1:0] rd_data
);
   logic [COEF_W-1:0] coef_mem_ff [DEPTH];

   // ==================================================
   // Write port; cleared at reset so the datapath never sees unknowns
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            coef_mem_ff[i] <= '0;
         end
      end else if (wr_en) begin
         coef_mem_ff[wr_addr] <= wr_data;
      end
   end

   // ==================================================
   // Read ports, one per accumulator bank
   always_comb begin
      for (int p = 0; p < PORTS; p++) begin
         rd_data[p] = coef_mem_ff[rd_addr[p]];
      end
   end
endmodule
`default_nettype wire

// ===== src/decimation_filter_trigger_latency.sv
// Symmetric decimating FIR with trigger-aligned zero run, sync word and kept outputs
// Behaviour
// (R1) Decimation factor 1 to 32; 16*M symmetric taps, half stored.
// (R2) For M of one, eight stored coefficients mirrored into sixteen taps.
// (R3) Rising trigger edge is captured and becomes the timing origin.
// (R4) Sample at trigger clock is input and output index zero.
// (R5) M plus one zero samples precede the sync word.
// (R6) Offset removal skipped: sync word at 16 plus M cycles.
// (R7) Offset removal skipped: first data at 17 plus M cycles.
// (R8) Offset removal active adds one cycle to sync and data.
// (R9) Low latency ADC mode changes neither latency.
// (R10) Outside party applies impulse M minus 3 cycles from trigger.
// (R11) Output 17+M sums inputs M-3 back to -15M-2, coefficients up then down.
// (R12) Keep first data after sync and every M-th after; drop the rest.
// (R13) With M of one, every filtered sample is passed.
// (R14) M of one: impulse with trigger yields coefficients 20 cycles later.
// (R15) Sync word takes exactly one slot between zeros and first data.
`timescale 1ns/100ps
`default_nettype none
module decimation_filter_trigger_latency #(
   parameter int SAMPLE_W = 14,
   parameter int COEF_W = 16,
   parameter int ACC_W = 40
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic trig_in,
   input wire logic [SAMPLE_W-1:0] sample_in,
   input wire logic [5:0] dec_factor,
   input wire logic offset_removal_skip,
   input wire logic [15:0] sync_word,
   input wire logic coef_wr_en,
   input wire logic [7:0] coef_wr_addr,
   input wire logic [COEF_W-1:0] coef_wr_data,
   output logic out_valid,
   output logic out_sync,
   output logic [ACC_W-1:0] out_data
);
   import dfl_pkg::*;

   typedef struct packed {
      seq_state_t st;
      logic [TRIG_SYNC_STAGES-1:0] trig_sy;
      logic [SAMPLE_DELAY-1:0][SAMPLE_W-1:0] dly;
      logic [BANKS-1:0][ACC_W-1:0] acc;
      logic [ACC_W-1:0] res;
      logic [RES_DEPTH-1:0][ACC_W-1:0] sh;
      logic [5:0] a;
      logic [3:0] head;
      logic [5:0] m;
      logic off;
      logic [7:0] n;
      logic [5:0] kp;
      logic out_valid;
      logic out_sync;
      logic [ACC_W-1:0] out_data;
   } core_t;

   core_t cur_ff;
   core_t nxt_state;
   logic [BANKS-1:0][7:0] rd_addr;
   logic [BANKS-1:0][COEF_W-1:0] rd_coef;

   coef_store #(
      .COEF_W(COEF_W),
      .DEPTH(COEF_DEPTH),
      .PORTS(BANKS)
   ) u_coef (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(coef_wr_en),
      .wr_addr(coef_wr_addr),
      .wr_data(coef_wr_data),
      .rd_addr(rd_addr),
      .rd_data(rd_coef)
   );

   // ==================================================
   // Tap addressing: bank d serves tap a + d*M of its pending output
   always_comb begin
      logic [8:0] j;
      j = '0;
      rd_addr = '0;
      for (int d = 0; d < BANKS; d++) begin
         j = 9'(cur_ff.a) + 9'(d) * 9'(cur_ff.m);
         rd_addr[d] = mirror_index(j, cur_ff.m); // [R1] [R2] [R11]
      end
   end

   // ==================================================
   // Next-state logic
   always_comb begin
      logic trig_edge;
      logic [3:0] slot;
      logic signed [COEF_W+SAMPLE_W-1:0] prod;
      logic [ACC_W-1:0] prod_ext;
      logic [7:0] nn;
      logic [7:0] zs;
      logic [7:0] sync_at;
      logic [7:0] data_at;
      logic [ACC_W-1:0] tap_val;
      logic [5:0] kp_n;
      logic in_zero;
      logic at_sync;
      logic at_data;
      logic phase_done;
      logic kp_last;

      nxt_state = cur_ff;
      trig_edge = 1'b0;
      slot = '0;
      prod = '0;
      prod_ext = '0;
      nn = '0;
      zs = '0;
      sync_at = '0;
      data_at = '0;
      tap_val = '0;
      kp_n = '0;
      in_zero = 1'b0;
      at_sync = 1'b0;
      at_data = 1'b0;
      phase_done = 1'b0;
      kp_last = 1'b0;
      // First stage only feeds the second; edge is taken one stage later
      nxt_state.trig_sy = {cur_ff.trig_sy[1:0], trig_in};
      trig_edge = cur_ff.trig_sy[1] & ~cur_ff.trig_sy[2]; // [R3]
      // Three-sample skew lets the completion phase restart at zero on the trigger
      nxt_state.dly = {cur_ff.dly[SAMPLE_DELAY-2:0], sample_in};

      // Transposed MAC: each sample feeds all sixteen pending outputs
      for (int d = 0; d < BANKS; d++) begin
         slot = cur_ff.head + 4'(d);
         prod = $signed(rd_coef[d]) * $signed(cur_ff.dly[SAMPLE_DELAY-1]);
         prod_ext = ACC_W'(prod);
         nxt_state.acc[slot] = cur_ff.acc[slot] + prod_ext; // [R11]
      end
      phase_done = (cur_ff.a == 6'h00);
      if (phase_done) begin
         nxt_state.res = cur_ff.acc[cur_ff.head] + ACC_W'($signed(rd_coef[0]) *
            $signed(cur_ff.dly[SAMPLE_DELAY-1]));
         nxt_state.acc[cur_ff.head] = '0;
         nxt_state.head = cur_ff.head + 4'h1;
         nxt_state.a = 6'(cur_ff.m - 6'h01);
      end else begin
         nxt_state.a = cur_ff.a - 6'h01;
      end
      nxt_state.sh = {cur_ff.sh[RES_DEPTH-2:0], cur_ff.res};

      // Slot sequencing; latency is fixed whatever ADC latency mode is in use
      nn = (cur_ff.n == SLOT_MAX) ? cur_ff.n : cur_ff.n + 8'h01; // [R4] [R9]
      zs = LEAD_ZERO_START + {7'h00, cur_ff.off}; // [R8]
      sync_at = SYNC_BASE + {2'b00, cur_ff.m} + {7'h00, cur_ff.off}; // [R6] [R8]
      data_at = DATA_BASE + {2'b00, cur_ff.m} + {7'h00, cur_ff.off}; // [R7] [R8]
      tap_val = cur_ff.sh[cur_ff.off ? RES_TAP_OFFSET : RES_TAP_SKIP]; // [R14]
      in_zero = (nn >= zs) && (nn < sync_at);
      at_sync = (nn == sync_at);
      at_data = (nn == data_at);
      nxt_state.out_valid = 1'b0;
      nxt_state.out_sync = 1'b0;
      nxt_state.out_data = '0;
      unique case (cur_ff.st)
         ST_IDLE: begin
            // Outputs stay at zero until the first trigger
         end
         ST_LEAD: begin
            nxt_state.n = nn;
            if (in_zero) begin
               nxt_state.out_valid = 1'b1; // [R5]
            end else if (at_sync) begin
               nxt_state.out_valid = 1'b1;
               nxt_state.out_sync = 1'b1; // [R15]
               nxt_state.out_data = ACC_W'(sync_word);
            end else if (at_data) begin
               nxt_state.out_valid = 1'b1;
               nxt_state.out_data = tap_val; // [R7]
               nxt_state.kp = '0;
               nxt_state.st = ST_RUN;
            end
         end
         ST_RUN: begin
            // Keep counter starts at the first data slot, so kept slots line up with sync
            kp_last = (cur_ff.kp >= cur_ff.m - 6'h01);
            kp_n = kp_last ? 6'h00 : cur_ff.kp + 6'h01;
            nxt_state.kp = kp_n;
            if (kp_n == 6'h00) begin
               nxt_state.out_valid = 1'b1; // [R12] [R13]
               nxt_state.out_data = tap_val;
            end
         end
      endcase

      // ==================================================
      // Trigger restart
      // Retrigger restarts the frame; pre-trigger partial sums keep their phase only
      // when triggers keep a constant phase modulo M
      if (trig_edge) begin
         nxt_state.st = ST_LEAD;
         nxt_state.n = 8'h01; // [R4]
         nxt_state.m = clamp_dec(dec_factor); // [R1]
         nxt_state.off = ~offset_removal_skip; // [R8]
         nxt_state.a = 6'(clamp_dec(dec_factor) - 6'h01);
         nxt_state.kp = '0;
      end
   end

   // ==================================================
   // State register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         // Coefficient memory clears itself on the same reset
         cur_ff <= '0;
         cur_ff.st <= ST_IDLE;
         cur_ff.m <= DEC_MIN;
      end else begin
         cur_ff <= nxt_state;
      end
   end

   // ==================================================
   // Registered outputs
   assign out_valid = cur_ff.out_valid;
   assign out_sync = cur_ff.out_sync;
   assign out_data = cur_ff.out_data;
endmodule
`default_nettype wire

// ===== src/dfl_pkg.sv
// Shared constants, types and helpers of the decimating filter with trigger alignment
`default_nettype none
package dfl_pkg;
   // ==================================================
   // Decimation factor range and filter geometry
   localparam logic [5:0] DEC_MIN = 6'h01;
   localparam logic [5:0] DEC_MAX = 6'h20;
   localparam int BANKS = 16;
   localparam int COEF_DEPTH = 256;
   localparam logic [2:0] HALF_TAP_SHIFT = 3'h3;
   localparam logic [3:0] FULL_TAP_SHIFT = 4'h4;

   // ==================================================
   // Timing counts, in ADC clock cycles after the trigger origin
   localparam int SAMPLE_DELAY = 3;
   localparam int TRIG_SYNC_STAGES = 3;
   localparam logic [7:0] LEAD_ZERO_START = 8'h0f;
   localparam logic [7:0] SYNC_BASE = 8'h10;
   localparam logic [7:0] DATA_BASE = 8'h11;
   localparam int RES_DEPTH = 16;
   localparam logic [3:0] RES_TAP_SKIP = 4'he;
   localparam logic [3:0] RES_TAP_OFFSET = 4'hf;
   localparam logic [7:0] SLOT_MAX = 8'hff;

   // ==================================================
   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LEAD = 3'b010,
      ST_RUN  = 3'b100
   } seq_state_t;

   // ==================================================
   // Helpers
   function automatic logic [5:0] clamp_dec(input logic [5:0] m);
      if (m < DEC_MIN) begin
         return DEC_MIN;
      end
      if (m > DEC_MAX) begin
         return DEC_MAX;
      end
      return m;
   endfunction

   function automatic logic [7:0] mirror_index(input logic [8:0] j, input logic [5:0] m);
      logic [9:0] span;
      logic [9:0] half;
      span = {4'h0, m} << FULL_TAP_SHIFT;
      half = {4'h0, m} << HALF_TAP_SHIFT;
      if ({1'b0, j} < half) begin
         return j[7:0];
      end
      return 8'(span - 10'h001 - {1'b0, j});
   endfunction
endpackage
`default_nettype wire

// ===== tb/dfl_checker.sv
// Slot timing checker for the decimating filter outputs
`timescale 1ns/100ps
`default_nettype none
module dfl_checker #(
   parameter int ACC_W = 40
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic trig_in,
   input wire logic [5:0] dec_factor,
   input wire logic offset_removal_skip,
   input wire logic [15:0] sync_word,
   input wire logic out_valid,
   input wire logic out_sync,
   input wire logic [ACC_W-1:0] out_data
);
   // ==================================================
   // Frame origin: cycles since the last rising trigger
   logic prev_ff;
   logic armed_ff;
   logic skip_ff;
   logic [5:0] m_ff;
   logic [15:0] cnt_ff;
   int d_sync;
   assign d_sync = 17 + int'(m_ff) + int'(!skip_ff);
   always_ff @(posedge ref_clk) begin
      prev_ff <= trig_in;
      if (rst) begin
         armed_ff <= 1'b0;
         cnt_ff <= 16'h0000;
      end else if (trig_in && !prev_ff) begin
         armed_ff <= 1'b1;
         cnt_ff <= 16'h0000;
         skip_ff <= offset_removal_skip;
         m_ff <= (dec_factor == 6'h00) ? 6'h01 : (dec_factor > 6'h20) ? 6'h20 : dec_factor;
      end else if (cnt_ff != 16'hffff) begin
         // Saturate so a long run never wraps into a false frame
         cnt_ff <= cnt_ff + 16'h0001;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ==================================================
   // Assertions
   sync_word_a: assert property (out_sync |-> out_valid && out_data == ACC_W'($past(sync_word)))
      else $error("sync slot content wrong");
   sync_single_a: assert property (out_sync |=> out_valid && !out_sync)
      else $error("sync not followed by data");
   zero_before_a: assert property (out_sync |-> $past(out_valid) && $past(out_data) == '0)
      else $error("sync not preceded by zero");
   idle_zero_a: assert property (!out_valid |-> out_data == '0 && !out_sync)
      else $error("data without valid");
   sync_lat_a: assert property (armed_ff && (out_sync || cnt_ff == 16'(d_sync))
      |-> out_sync && cnt_ff == 16'(d_sync))
      else $error("sync latency wrong");
   zero_run_a: assert property (armed_ff && cnt_ff >= 16'(d_sync - int'(m_ff) - 1) && cnt_ff < 16'(d_sync)
      |-> out_valid && !out_sync && out_data == '0)
      else $error("zero run wrong");
   keep_slot_a: assert property (armed_ff && cnt_ff > 16'(d_sync) && cnt_ff < 16'hffff
      |-> out_valid == ((int'(cnt_ff) - d_sync - 1) % int'(m_ff) == 0))
      else $error("kept slot pattern wrong");
   // Old frame may still emit for three cycles while the trigger is synchronised
   early_slot_a: assert property (armed_ff && out_valid && cnt_ff >= 16'h0003 && cnt_ff < 16'(d_sync)
      |-> cnt_ff >= 16'(d_sync - int'(m_ff) - 1))
      else $error("early output slot");
endmodule
bind decimation_filter_trigger_latency dfl_checker #(.ACC_W(ACC_W)) chk_i (.ref_clk(ref_clk), .rst(rst),
   .trig_in(trig_in), .dec_factor(dec_factor), .offset_removal_skip(offset_removal_skip), .sync_word(sync_word),
   .out_valid(out_valid), .out_sync(out_sync), .out_data(out_data));
`default_nettype wire

// ===== tb/dfl_receiver.sv
// Receiving side model: counts kept words since the last sync word
`timescale 1ns/100ps
`default_nettype none
module dfl_receiver (
   input wire logic ref_clk,
   input wire logic out_valid,
   input wire logic out_sync,
   output logic [7:0] kept_ff
);
   always_ff @(posedge ref_clk) begin
      if (out_sync) begin
         kept_ff <= 8'h00;
      end else if (out_valid) begin
         kept_ff <= kept_ff + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for trigger-aligned decimating filter output
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic ref_clk = 0, rst = 1, trig_in = 0, skip = 1, wr = 0;
   logic [13:0] smp = 14'h0000;
   logic [5:0] dec = 6'h01;
   logic [7:0] wa = 8'h00;
   logic [15:0] wd = 16'h0000;
   logic out_valid, out_sync;
   logic [39:0] out_data;
   logic [7:0] kept;
   int mismatches = 0, total_checks = 0;
   localparam logic [15:0] SYNC = 16'ha5c3;
   decimation_filter_trigger_latency uut (.ref_clk(ref_clk), .rst(rst), .trig_in(trig_in), .sample_in(smp),
      .dec_factor(dec), .offset_removal_skip(skip), .sync_word(SYNC), .coef_wr_en(wr), .coef_wr_addr(wa),
      .coef_wr_data(wd), .out_valid(out_valid), .out_sync(out_sync), .out_data(out_data));
   dfl_receiver rx (.ref_clk(ref_clk), .out_valid(out_valid), .out_sync(out_sync), .kept_ff(kept));
   initial forever #4 ref_clk = ~ref_clk;
   // ==================================================
   // Comparison and verdict
   task automatic chk(input string n, input logic [39:0] exp, input logic [39:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==================================================
   // One frame: trigger, impulse at M-3, slot by slot judgement
   task automatic frame(input logic [5:0] dv, input logic sk, input logic vals);
      int me, d, s, k;
      logic [39:0] e;
      me = (dv == 6'h00) ? 1 : (dv > 6'h20) ? 32 : int'(dv);
      d = 17 + me + (sk ? 0 : 1);
      // Quiet gap drains every partial sum of the previous frame
      repeat (600) @(posedge ref_clk);
      #1;
      dec = dv;
      skip = sk;
      trig_in = 1'b1;
      smp = (me == 1) ? 14'h0003 : 14'h0000;
      for (int c = 0; c < d + 2 + 15 * me; c++) begin
         @(posedge ref_clk);
         #1;
         trig_in = c < 2;
         smp = (c + 1 == me - 1) ? 14'h0003 : 14'h0000;
         s = c - d;
         k = s - 1;
         if (c >= 16) begin
            chk("valid", 40'((s >= -me - 1 && s <= 0) || (s > 0 && k % me == 0)), 40'(out_valid));
            chk("sync", 40'(s == 0), 40'(out_sync));
            e = (s == 0) ? 40'(SYNC) : (s > 0 && k % me == 0) ? 40'(3 * (k < 8 * me ? k + 1 : 16 * me - k)) : '0;
            if (s <= 0 || vals) chk("data", e, out_data);
         end
      end
      @(posedge ref_clk);
      #1;
      chk("kept", 40'(16), 40'(kept));
   endtask
   task automatic t_m1;
      frame(6'h01, 1'b1, 1'b1);
      $display("test m1 done");
   endtask
   task automatic t_m3;
      frame(6'h03, 1'b1, 1'b1);
      $display("test m3 done");
   endtask
   task automatic t_offset;
      frame(6'h02, 1'b0, 1'b1);
      $display("test offset done");
   endtask
   task automatic t_limits;
      frame(6'h28, 1'b1, 1'b1);
      frame(6'h00, 1'b1, 1'b1);
      $display("test limits done");
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      #1;
      rst = 0;
      // Full depth load; each size reads its own half
      for (int i = 0; i < 256; i++) begin
         wr = 1'b1;
         wa = 8'(i);
         wd = 16'(i + 1);
         @(posedge ref_clk);
         #1;
      end
      wr = 1'b0;
      t_m1;
      t_m3;
      t_offset;
      t_limits;
      close_out;
   end
endmodule
`default_nettype wire
